// [rtl/gpio_pin_sync.sv]
// three-flop input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_sync
	import gpio_port_pkg::*;
#(
	parameter int WIDTH = 14
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// pins and filtered result
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage_a;
	logic [WIDTH-1:0] stage_b;
	logic [WIDTH-1:0] stage_c;

	initial begin
		if (WIDTH < 1)
			$error("gpio_pin_sync: WIDTH must be positive");
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stage_a <= '0;
			stage_b <= '0;
			stage_c <= '0;
		end else begin
			stage_a <= async_i;
			stage_b <= stage_a;
			stage_c <= stage_b;
		end
	end

	// value changes only once the second and third flops agree
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			sync_o <= '0;
		else
			for (int i = 0; i < WIDTH; i++)
				if (stage_b[i] == stage_c[i])
					sync_o[i] <= stage_c[i];
	end
endmodule
`default_nettype wire

// [rtl/gpio_port_pin_mux.sv]
// fourteen-pin port with per-pin function mux, pad control and pin interrupts
`timescale 1ns/10ps
`default_nettype none
module gpio_port_pin_mux
	import gpio_port_pkg::*;
#(
	parameter int PINS = PIN_COUNT
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// firmware configuration writes: one strobe per carrier, data per pin
	input wire logic cfg_write_i,
	input wire pin_cfg_s cfg_data_i,
	input wire logic irq_cfg_write_i,
	input wire irq_cfg_s irq_cfg_data_i,
	input wire logic [PINS-1:0] pending_clear_i,
	input wire logic debug_port_disable_i,
	// firmware read-back
	output pin_cfg_s cfg_o,
	output irq_cfg_s irq_cfg_o,
	output logic [PINS-1:0] input_value_register_o,
	output logic [PINS-1:0] pin_irq_pending_o,
	output logic debug_port_disable_o,
	// peripheral side, three functions per pin
	input wire logic [PINS-1:0] func_out_i [FUNC_COUNT],
	input wire logic [PINS-1:0] func_oe_i [FUNC_COUNT],
	output logic [PINS-1:0] func_in_o,
	output logic [PINS-1:0] debug_in_o,
	// pads
	input wire logic [PINS-1:0] pad_in_i,
	output logic [PINS-1:0] pad_out_o,
	output logic [PINS-1:0] pad_oe_o,
	output pad_ctl_s pad_ctl_o,
	// events
	output logic port_irq_o,
	output logic wake_request_o
);
	pin_cfg_s cfg;
	irq_cfg_s irq_cfg;
	logic debug_disable;
	logic [PINS-1:0] pin_sync;
	logic [PINS-1:0] pin_prev;
	logic [PINS-1:0] pending;
	logic [PINS-1:0] trigger;
	logic [PINS-1:0] wake_hit;
	logic [PINS-1:0] firmware_mode;
	logic [PIN_COUNT-1:0] mode_select_low;
	logic [PIN_COUNT-1:0] mode_select_high;
	logic [PIN_COUNT-1:0] output_level;
	logic [PIN_COUNT-1:0] output_driver_enable;
	logic [PIN_COUNT-1:0] pull_resistor_enable;
	logic [PIN_COUNT-1:0] pull_up_select;
	logic [PIN_COUNT-1:0] drive_select_low;
	logic [PIN_COUNT-1:0] drive_select_high;
	logic [PIN_COUNT-1:0] slew_fast;
	logic [PIN_COUNT-1:0] hysteresis_enable;
	logic [PIN_COUNT-1:0] input_enable;
	logic [PIN_COUNT-1:0] pin_irq_enable;
	logic [PIN_COUNT-1:0] pin_irq_trigger_type;
	logic [PIN_COUNT-1:0] pin_irq_polarity;
	logic [PIN_COUNT-1:0] pin_irq_both_edges;
	logic [PIN_COUNT-1:0] wake_enable;

	// carriers are fixed at the full port width
	initial begin
		if (PINS != PIN_COUNT)
			$error("gpio_port_pin_mux: PINS must equal PIN_COUNT");
	end

	// configuration storage, one register per field, rewritable anytime
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			mode_select_low <= RST_MODE_SELECT_LOW;
		else if (cfg_write_i)
			mode_select_low <= cfg_data_i.mode_select_low;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			mode_select_high <= RST_MODE_SELECT_HIGH;
		else if (cfg_write_i)
			mode_select_high <= cfg_data_i.mode_select_high;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			output_level <= RST_ZERO;
		else if (cfg_write_i)
			output_level <= cfg_data_i.output_level;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			output_driver_enable <= RST_OUTPUT_DRIVER_ENABLE;
		else if (cfg_write_i)
			output_driver_enable <= cfg_data_i.output_driver_enable;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pull_resistor_enable <= RST_ZERO;
		else if (cfg_write_i)
			pull_resistor_enable <= cfg_data_i.pull_resistor_enable;
	end

	// two-wire pins never take a pull-up
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pull_up_select <= RST_ZERO;
		else if (cfg_write_i)
			pull_up_select <= cfg_data_i.pull_up_select & ~TWO_WIRE_PINS;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			drive_select_low <= RST_ZERO;
		else if (cfg_write_i)
			drive_select_low <= cfg_data_i.drive_select_low;
	end

	// two-wire pins: low drive select only, no slew control
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			drive_select_high <= RST_ZERO;
		else if (cfg_write_i)
			drive_select_high <= cfg_data_i.drive_select_high & ~TWO_WIRE_PINS;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			slew_fast <= RST_ZERO;
		else if (cfg_write_i)
			slew_fast <= cfg_data_i.slew_fast & ~TWO_WIRE_PINS;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			hysteresis_enable <= RST_ZERO;
		else if (cfg_write_i)
			hysteresis_enable <= cfg_data_i.hysteresis_enable;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			input_enable <= ~RST_ZERO;
		else if (cfg_write_i)
			input_enable <= cfg_data_i.input_enable;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pin_irq_enable <= RST_ZERO;
		else if (irq_cfg_write_i)
			pin_irq_enable <= irq_cfg_data_i.pin_irq_enable;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pin_irq_trigger_type <= RST_ZERO;
		else if (irq_cfg_write_i)
			pin_irq_trigger_type <= irq_cfg_data_i.pin_irq_trigger_type;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pin_irq_polarity <= RST_ZERO;
		else if (irq_cfg_write_i)
			pin_irq_polarity <= irq_cfg_data_i.pin_irq_polarity;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pin_irq_both_edges <= RST_ZERO;
		else if (irq_cfg_write_i)
			pin_irq_both_edges <= irq_cfg_data_i.pin_irq_both_edges;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			wake_enable <= RST_ZERO;
		else if (irq_cfg_write_i)
			wake_enable <= irq_cfg_data_i.wake_enable;
	end

	assign cfg = '{
		mode_select_low: mode_select_low,
		mode_select_high: mode_select_high,
		output_level: output_level,
		output_driver_enable: output_driver_enable,
		pull_resistor_enable: pull_resistor_enable,
		pull_up_select: pull_up_select,
		drive_select_low: drive_select_low,
		drive_select_high: drive_select_high,
		slew_fast: slew_fast,
		hysteresis_enable: hysteresis_enable,
		input_enable: input_enable
	};

	assign irq_cfg = '{
		pin_irq_enable: pin_irq_enable,
		pin_irq_trigger_type: pin_irq_trigger_type,
		pin_irq_polarity: pin_irq_polarity,
		pin_irq_both_edges: pin_irq_both_edges,
		wake_enable: wake_enable
	};

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			debug_disable <= 1'b0;
		else
			debug_disable <= debug_port_disable_i;
	end

	gpio_pin_sync #(
		.WIDTH(PINS)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.async_i(pad_in_i),
		.sync_o(pin_sync)
	);

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pin_prev <= '0;
		else
			pin_prev <= pin_sync;
	end

	// per-pin mux, pad control and trigger detection
	generate
		for (genvar p = 0; p < PINS; p++) begin : g_pin
			logic [1:0] mode;
			logic rise;
			logic fall;
			assign mode = {cfg.mode_select_high[p], cfg.mode_select_low[p]};
			assign firmware_mode[p] = (mode == MODE_FIRMWARE);
			assign rise = pin_sync[p] & ~pin_prev[p];
			assign fall = ~pin_sync[p] & pin_prev[p];

			always_comb begin
				case (mode)
					MODE_FIRMWARE: begin
						pad_out_o[p] = cfg.output_level[p];
						pad_oe_o[p] = cfg.output_driver_enable[p];
					end
					MODE_FUNC_ONE: begin
						pad_out_o[p] = func_out_i[0][p];
						pad_oe_o[p] = func_oe_i[0][p];
						// debug pins released when the debug port is disabled
						if ((p == DEBUG_PIN_ZERO || p == DEBUG_PIN_ONE) && debug_disable) begin
							pad_out_o[p] = cfg.output_level[p];
							pad_oe_o[p] = cfg.output_driver_enable[p];
						end
					end
					MODE_FUNC_TWO: begin
						pad_out_o[p] = func_out_i[1][p];
						pad_oe_o[p] = func_oe_i[1][p];
					end
					MODE_FUNC_THREE: begin
						pad_out_o[p] = func_out_i[2][p];
						pad_oe_o[p] = func_oe_i[2][p];
					end
					default: begin
						pad_out_o[p] = 1'b0;
						pad_oe_o[p] = 1'b0;
					end
				endcase
			end

			// pad electrical controls
			assign pad_ctl_o.pull_enable[p] = cfg.pull_resistor_enable[p];
			assign pad_ctl_o.pull_up[p] = cfg.pull_up_select[p];
			assign pad_ctl_o.drive_low[p] = cfg.drive_select_low[p];
			assign pad_ctl_o.drive_high[p] = cfg.drive_select_high[p];
			assign pad_ctl_o.slew_fast[p] = cfg.slew_fast[p];
			assign pad_ctl_o.hysteresis[p] = cfg.hysteresis_enable[p];

			// peripheral input path, gated by input enable and held low in firmware mode; debug input gated by debug disable only
			assign func_in_o[p] = pin_sync[p] & cfg.input_enable[p] & ~firmware_mode[p];
			assign debug_in_o[p] = pin_sync[p] & ~debug_disable;

			always_comb begin
				if (!irq_cfg.pin_irq_trigger_type[p])
					trigger[p] = (pin_sync[p] == irq_cfg.pin_irq_polarity[p]);
				else if (irq_cfg.pin_irq_both_edges[p])
					trigger[p] = rise | fall;
				else if (irq_cfg.pin_irq_polarity[p])
					trigger[p] = fall;
				else
					trigger[p] = rise;
			end

			assign wake_hit[p] = irq_cfg.wake_enable[p] & (irq_cfg.pin_irq_both_edges[p] ? (rise | fall) :
				(irq_cfg.pin_irq_polarity[p] ? fall : rise));
		end
	endgenerate

	// pending flags: set wins over a same-cycle write-one clear
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pending <= '0;
		else
			pending <= (pending & ~pending_clear_i) |
				(trigger & irq_cfg.pin_irq_enable & firmware_mode);
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			input_value_register_o <= '0;
		else
			input_value_register_o <= pin_sync & cfg.input_enable;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			wake_request_o <= 1'b0;
		else
			wake_request_o <= |wake_hit;
	end

	assign port_irq_o = |(pending & irq_cfg.pin_irq_enable);
	assign pin_irq_pending_o = pending;
	assign cfg_o = cfg;
	assign irq_cfg_o = irq_cfg;
	assign debug_port_disable_o = debug_disable;
endmodule
`default_nettype wire

// [rtl/gpio_port_pkg.sv]
// shared constants and carriers for the pin-mux port
package gpio_port_pkg;
	localparam int PIN_COUNT = 14;
	localparam int FUNC_COUNT = 3;
	// mode code {mode_select_high, mode_select_low}
	localparam logic [1:0] MODE_FUNC_ONE = 2'h0;
	localparam logic [1:0] MODE_FIRMWARE = 2'h1;
	localparam logic [1:0] MODE_FUNC_TWO = 2'h2;
	localparam logic [1:0] MODE_FUNC_THREE = 2'h3;
	// reset values: debug pins zero and one in function one, rest firmware input
	localparam logic [13:0] RST_MODE_SELECT_LOW = 14'h3ffc;
	localparam logic [13:0] RST_MODE_SELECT_HIGH = 14'h0000;
	localparam logic [13:0] RST_OUTPUT_DRIVER_ENABLE = 14'h0002;
	localparam logic [13:0] RST_ZERO = 14'h0000;
	// two-wire bus pins: no pull-up, no slew, two drive levels
	localparam logic [13:0] TWO_WIRE_PINS = 14'h030c;
	localparam int DEBUG_PIN_ZERO = 0;
	localparam int DEBUG_PIN_ONE = 1;
	localparam int SYNC_STAGES = 3;

	typedef struct packed {
		logic [13:0] mode_select_low;
		logic [13:0] mode_select_high;
		logic [13:0] output_level;
		logic [13:0] output_driver_enable;
		logic [13:0] pull_resistor_enable;
		logic [13:0] pull_up_select;
		logic [13:0] drive_select_low;
		logic [13:0] drive_select_high;
		logic [13:0] slew_fast;
		logic [13:0] hysteresis_enable;
		logic [13:0] input_enable;
	} pin_cfg_s;

	typedef struct packed {
		logic [13:0] pin_irq_enable;
		logic [13:0] pin_irq_trigger_type;
		logic [13:0] pin_irq_polarity;
		logic [13:0] pin_irq_both_edges;
		logic [13:0] wake_enable;
	} irq_cfg_s;

	typedef struct packed {
		logic [13:0] pull_enable;
		logic [13:0] pull_up;
		logic [13:0] drive_low;
		logic [13:0] drive_high;
		logic [13:0] slew_fast;
		logic [13:0] hysteresis;
	} pad_ctl_s;
endpackage

// [testbench/gpio_pad_model.sv]
// pad-side model: resolves each pin from driver, board source and pull
`timescale 1ns/10ps
`default_nettype none
module gpio_pad_model
	import gpio_port_pkg::*;
(
	// clock
	input wire logic clk_sys_i,
	// from the port
	input wire logic [13:0] pad_out_i,
	input wire logic [13:0] pad_oe_i,
	input wire pad_ctl_s pad_ctl_i,
	// board source
	input wire logic [13:0] ext_level_i,
	input wire logic [13:0] ext_drive_i,
	// pin levels
	output logic [13:0] pad_level_o
);
	logic [13:0] noise = 14'h2aaa;
	always @(posedge clk_sys_i) noise <= ~noise;
	always_comb begin
		for (int p = 0; p < 14; p++) begin
			if (pad_oe_i[p])
				pad_level_o[p] = pad_out_i[p];
			else if (ext_drive_i[p])
				pad_level_o[p] = ext_level_i[p];
			else if (pad_ctl_i.pull_enable[p])
				pad_level_o[p] = pad_ctl_i.pull_up[p];
			else
				pad_level_o[p] = noise[p];
		end
	end
endmodule
`default_nettype wire

// [testbench/gpio_port_pin_mux_bench.sv]
// self-checking bench for the pin-mux port
`timescale 1ns/10ps
`default_nettype none
module gpio_port_pin_mux_bench
	import gpio_port_pkg::*;
;
	logic clk_sys_i = 0;
	logic reset_n_i = 0;
	logic wr_stb = 0;
	pin_cfg_s c = '0;
	pin_cfg_s cd = '0;
	irq_cfg_s q = '0;
	irq_cfg_s qd = '0;
	logic [13:0] pending_clear_i = '0;
	logic debug_port_disable_i = 0;
	logic [13:0] func_out_i [FUNC_COUNT] = '{14'h1236, 14'h2a5a, 14'h0f69};
	logic [13:0] func_oe_i [FUNC_COUNT] = '{14'h3c3c, 14'h0ff0, 14'h3333};
	logic [13:0] ext_level = '0;
	logic [13:0] ext_drive = 14'h3fff;
	pin_cfg_s cfg_o;
	irq_cfg_s irq_cfg_o;
	pad_ctl_s pad_ctl_o;
	logic [13:0] input_value_register_o, pin_irq_pending_o, func_in_o, debug_in_o;
	logic [13:0] pad_in_i, pad_out_o, pad_oe_o;
	logic port_irq_o, wake_request_o, debug_port_disable_o;
	int err_total = 0, total_checks = 0, cycles = 0, wakes = 0;
	always #25 clk_sys_i = ~clk_sys_i;
	gpio_port_pin_mux uut (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.cfg_write_i(wr_stb),
		.cfg_data_i(cd),
		.irq_cfg_write_i(wr_stb),
		.irq_cfg_data_i(qd),
		.pending_clear_i(pending_clear_i),
		.debug_port_disable_i(debug_port_disable_i),
		.cfg_o(cfg_o),
		.irq_cfg_o(irq_cfg_o),
		.input_value_register_o(input_value_register_o),
		.pin_irq_pending_o(pin_irq_pending_o),
		.debug_port_disable_o(debug_port_disable_o),
		.func_out_i(func_out_i),
		.func_oe_i(func_oe_i),
		.func_in_o(func_in_o),
		.debug_in_o(debug_in_o),
		.pad_in_i(pad_in_i),
		.pad_out_o(pad_out_o),
		.pad_oe_o(pad_oe_o),
		.pad_ctl_o(pad_ctl_o),
		.port_irq_o(port_irq_o),
		.wake_request_o(wake_request_o)
	);
	gpio_pad_model pads (.clk_sys_i(clk_sys_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .pad_ctl_i(pad_ctl_o),
		.ext_level_i(ext_level), .ext_drive_i(ext_drive), .pad_level_o(pad_in_i));
	always @(posedge clk_sys_i) begin
		cycles++;
		if (wake_request_o === 1'b1)
			wakes++;
		if (cycles == 3000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic complete_run;
		if (err_total == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [13:0] s, input logic [13:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic wr;
		@(posedge clk_sys_i);
		cd <= c;
		qd <= q;
		wr_stb <= 1;
		@(posedge clk_sys_i);
		wr_stb <= 0;
		#1;
	endtask
	task automatic edge_set(input logic [13:0] lvl, input logic [13:0] clr);
		@(posedge clk_sys_i);
		ext_level <= lvl;
		// clear only once the filtered edge has landed
		repeat (8) @(posedge clk_sys_i);
		pending_clear_i <= clr;
		@(posedge clk_sys_i);
		pending_clear_i <= '0;
		tick(1);
	endtask
	function automatic logic [13:0] emux(input logic [13:0] lo, hi, f, a, b, d);
		for (int p = 0; p < 14; p++)
			emux[p] = (lo[p] & !hi[p]) ? f[p] : (hi[p] ? (lo[p] ? d[p] : b[p]) : a[p]);
	endfunction
	task automatic t_reset;
		chk("mode_lo", cfg_o.mode_select_low, 14'h3ffc);
		chk("mode_hi", cfg_o.mode_select_high, 14'h0000);
		chk("drv_en", cfg_o.output_driver_enable & 14'h3ffc, 14'h0000);
		chk("pull_en", cfg_o.pull_resistor_enable, 14'h0000);
		chk("irq_en", irq_cfg_o.pin_irq_enable, 14'h0000);
		chk("dbg_out", 14'(pad_out_o[1:0]), 14'h0002);
	endtask
	task automatic t_modes;
		logic [13:0] lo [5] = '{14'h3fff, 14'h0000, 14'h0000, 14'h3fff, 14'h0f0f};
		logic [13:0] hi [5] = '{14'h0000, 14'h0000, 14'h3fff, 14'h3fff, 14'h3355};
		logic [13:0] eoe;
		c.output_level = 14'h2d2d;
		c.output_driver_enable = 14'h1ff8;
		c.input_enable = 14'h3fff;
		for (int i = 0; i < 5; i++) begin
			c.mode_select_low = lo[i];
			c.mode_select_high = hi[i];
			wr();
			eoe = emux(lo[i], hi[i], c.output_driver_enable, func_oe_i[0], func_oe_i[1], func_oe_i[2]);
			chk("pad_oe", pad_oe_o, eoe);
			eoe = eoe & emux(lo[i], hi[i], c.output_level, func_out_i[0], func_out_i[1], func_out_i[2]);
			chk("pad_out", pad_out_o & pad_oe_o, eoe);
		end
	endtask
	task automatic t_input;
		c.mode_select_low = 14'h0000;
		c.mode_select_high = 14'h3355;
		wr();
		@(posedge clk_sys_i);
		func_oe_i <= '{14'h0000, 14'h0000, 14'h0000};
		ext_level <= 14'h25a9;
		tick(7);
		chk("in_alt", input_value_register_o, 14'h25a9);
		chk("func_in", func_in_o, 14'h25a9);
		chk("dbg_in", debug_in_o, 14'h25a9);
		c.input_enable = 14'h00ff;
		wr();
		tick(3);
		chk("in_mask", input_value_register_o, 14'h00a9);
		func_oe_i <= '{14'h3c3c, 14'h0ff0, 14'h3333};
	endtask
	task automatic t_pads;
		c = '0;
		c.mode_select_low = 14'h3fff;
		c.input_enable = 14'h3fff;
		c.pull_resistor_enable = 14'h3fff;
		c.pull_up_select = 14'h3fff;
		c.drive_select_low = 14'h3fff;
		c.drive_select_high = 14'h3fff;
		c.slew_fast = 14'h3fff;
		c.hysteresis_enable = 14'h1555;
		wr();
		ext_drive <= 14'h3fe7;
		tick(7);
		chk("pull_up", pad_ctl_o.pull_up, 14'h3cf3);
		chk("drv_lo", pad_ctl_o.drive_low, 14'h3fff);
		chk("drv_hi", pad_ctl_o.drive_high, 14'h3cf3);
		chk("slew", pad_ctl_o.slew_fast, 14'h3cf3);
		chk("hyst", pad_ctl_o.hysteresis, 14'h1555);
		chk("pulled", input_value_register_o & 14'h0018, 14'h0010);
		ext_drive <= 14'h3fff;
		c.pull_resistor_enable = '0;
	endtask
	task automatic t_irq;
		int w0;
		q = '{14'h01f0, 14'h0070, 14'h00a0, 14'h0040, 14'h0010};
		wr();
		edge_set(14'h0000, 14'h3fff);
		w0 = wakes;
		edge_set(14'h00f0, 14'h0000);
		chk("rise", pin_irq_pending_o, 14'h01d0);
		chk("irq_on", 14'(port_irq_o), 14'h0001);
		chk("wake", 14'(wakes - w0), 14'h0001);
		edge_set(14'h0000, 14'h0000);
		chk("fall", pin_irq_pending_o, 14'h01f0);
		// pin eight stays low: its level trigger beats the clear
		edge_set(14'h0000, 14'h0190);
		chk("clear", pin_irq_pending_o, 14'h0160);
		q.pin_irq_enable = 14'h0000;
		wr();
		chk("irq_off", 14'(port_irq_o), 14'h0000);
	endtask
	task automatic t_debug;
		c.mode_select_low = 14'h3ffc;
		c.output_driver_enable = 14'h0001;
		wr();
		debug_port_disable_i <= 1;
		tick(2);
		chk("dbg_dis", 14'(debug_port_disable_o), 14'h0001);
		chk("dbg_io", 14'(pad_oe_o[1:0]), 14'h0001);
		chk("dbg_in_off", debug_in_o, 14'h0000);
	endtask
	initial begin
		repeat (20) @(posedge clk_sys_i);
		reset_n_i <= 1;
		tick(1);
		t_reset();
		t_modes();
		t_input();
		t_pads();
		t_irq();
		t_debug();
		complete_run();
	end
endmodule
`default_nettype wire

// [testbench/gpio_port_pin_mux_chk.sv]
// boundary assertions for the pin-mux port
`timescale 1ns/10ps
`default_nettype none
module gpio_port_pin_mux_chk
	import gpio_port_pkg::*;
#(
	parameter int PINS = PIN_COUNT
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// watched ports
	input wire pin_cfg_s cfg_o,
	input wire irq_cfg_s irq_cfg_o,
	input wire pad_ctl_s pad_ctl_o,
	input wire logic [PINS-1:0] pad_in_i,
	input wire logic [PINS-1:0] pad_out_o,
	input wire logic [PINS-1:0] pad_oe_o,
	input wire logic [PINS-1:0] input_value_register_o,
	input wire logic [PINS-1:0] pin_irq_pending_o,
	input wire logic port_irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	logic [PINS-1:0] fw;
	assign fw = cfg_o.mode_select_low & ~cfg_o.mode_select_high;
	sequence pins_quiet;
		($stable(pad_in_i) && $stable(cfg_o.input_enable)) [*7];
	endsequence
	irq_merge_a: assert property (port_irq_o == |(pin_irq_pending_o & irq_cfg_o.pin_irq_enable))
		else $error("common interrupt wrong");
	fw_enable_a: assert property (((pad_oe_o ^ cfg_o.output_driver_enable) & fw) == '0)
		else $error("firmware driver enable wrong");
	fw_level_a: assert property (((pad_out_o ^ cfg_o.output_level) & fw & pad_oe_o) == '0)
		else $error("firmware output level wrong");
	no_pullup_a: assert property ((pad_ctl_o.pull_up & TWO_WIRE_PINS) == '0)
		else $error("pull-up on two-wire pin");
	two_drive_a: assert property (((pad_ctl_o.slew_fast | pad_ctl_o.drive_high) & TWO_WIRE_PINS) == '0)
		else $error("slew or high drive on two-wire pin");
	pull_map_a: assert property (pad_ctl_o.pull_enable == cfg_o.pull_resistor_enable)
		else $error("pull enable not passed to pad");
	input_sync_a: assert property (pins_quiet |-> input_value_register_o == (pad_in_i & cfg_o.input_enable))
		else $error("input value not pin state");
	pend_gate_a: assert property ((pin_irq_pending_o & ~$past(pin_irq_pending_o)
		& ~($past(fw) & $past(irq_cfg_o.pin_irq_enable))) == '0)
		else $error("pending set outside firmware mode");
endmodule
bind gpio_port_pin_mux gpio_port_pin_mux_chk #(
	.PINS(PINS)
) chk (
	.clk_sys_i(clk_sys_i),
	.reset_n_i(reset_n_i),
	.cfg_o(cfg_o),
	.irq_cfg_o(irq_cfg_o),
	.pad_ctl_o(pad_ctl_o),
	.pad_in_i(pad_in_i),
	.pad_out_o(pad_out_o),
	.pad_oe_o(pad_oe_o),
	.input_value_register_o(input_value_register_o),
	.pin_irq_pending_o(pin_irq_pending_o),
	.port_irq_o(port_irq_o)
);
`default_nettype wire
